// ---- hw/acv_ctrl.v ----
`timescale 1ns/10ps
`default_nettype none
`include "acv_defs.vh"
// Summary of operation
// - four per-channel attenuator bypass bits sit in the top nibble of register 0x7D
// - bit4 2.5 V, bit5 core rail, bit6 5.0 V, bit7 12 V
// - 0x73 bit4 turns averaging off; bit5 bypasses every voltage attenuator
// - 0x73 bit6 leaves round-robin and enters single-channel mode
// - single-channel mode converts only the chosen channel every 0.7 ms
// - the chosen channel comes from bits 7:5 of register 0x55
// - codes 0..7 select 2.5V, core, supply, 5V, 12V, rem1, local, rem2
// - channel select and tach limit share 0x55; writing one alters the other
// - results are unsigned 10-bit, saturating at 1023
// - identification bits 0..4 follow the five dedicated input pins
// - identification bit 5 reads zero while the shared pin measures 12 V
// - identification bit 5 follows the shared pin when it is an id input
// - identification bit 6 is a writable low-threshold select
// - shared pin may serve as sixth id input; then no 12 V measurement
// - identification bit 7 selects the shared pin role
// - with averaging on, each stored value is the mean of sixteen conversions
module acv_ctrl (
    input wire ref_clk,
    input wire rst_n,
    input wire reg_wr,
    input wire reg_rd,
    input wire [7:0] reg_addr,
    input wire [7:0] reg_wdata,
    output reg [7:0] reg_rdata,
    output reg reg_rvalid,
    input wire [4:0] voltage_id_pins,
    input wire voltage_id_bit5_shared,
    input wire adc_done,
    input wire [10:0] adc_raw,
    output reg adc_start,
    output reg [2:0] adc_channel,
    output reg adc_atten_bypass,
    output reg low_threshold_select,
    output reg shared_pin_role_select,
    output reg single_mode,
    output reg [7:0] value_valid,
    output reg [79:0] value_flat
);
    localparam ST_IDLE = 2'h0;
    localparam ST_WAIT = 2'h1;
    localparam ST_CONV = 2'h2;
    localparam [19:0] CONV_CYCLES = `ACV_CONV_CYCLES;

    reg [7:0] chsel_q;
    reg [7:0] cfg2_q;
    reg [7:0] byp_q;
    reg low_low_threshold_select_q;
    reg role_q;
    reg [5:0] vid_q;
    reg [1:0] st_q;
    reg [19:0] tmr_q;
    reg [2:0] rr_ch_q;
    reg [2:0] cur_ch_q;
    reg cur_single_q;
    reg cur_avg_off_q;
    reg [9:0] sample_q;
    reg sample_vld_q;
    reg [9:0] val_q [0:7];
    reg [7:0] vld_q;
    wire avg_vld;
    wire [9:0] avg_res;
    wire [2:0] sel_ch = chsel_q[`ACV_CHSEL_HI:`ACV_CHSEL_LO];
    // single mode takes the field, otherwise the round-robin pointer
    wire [2:0] start_ch = route_ch(cfg2_q[`ACV_CFG2_SINGLE] ? sel_ch : rr_ch_q, role_q);

    // bypass for a channel: global bit or its own bit, global bit alone for supply (voltage channels only)
    function byp_for;
        input [2:0] ch;
        input [7:0] cfg2;
        input [7:0] byp;
        begin
            case (ch)
                `ACV_CH_2V5: byp_for = cfg2[`ACV_CFG2_BYP_ALL] | byp[`ACV_BYP_LO];
                `ACV_CH_CORE: byp_for = cfg2[`ACV_CFG2_BYP_ALL] | byp[`ACV_BYP_LO + 1];
                `ACV_CH_SUPPLY: byp_for = cfg2[`ACV_CFG2_BYP_ALL];
                `ACV_CH_5V0: byp_for = cfg2[`ACV_CFG2_BYP_ALL] | byp[`ACV_BYP_LO + 2];
                `ACV_CH_12V: byp_for = cfg2[`ACV_CFG2_BYP_ALL] | byp[`ACV_BYP_LO + 3];
                default: byp_for = 1'b0;
            endcase
        end
    endfunction

    // 12 V code becomes remote 1 while the pin carries an id bit;
    // a single-mode 12 V request then lands in the remote 1 slot
    function [2:0] route_ch;
        input [2:0] ch;
        input role;
        begin
            if (role && ch == `ACV_CH_12V) begin
                route_ch = `ACV_CH_REM1;
            end else begin
                route_ch = ch;
            end
        end
    endfunction

    // next round-robin channel, skipping 12 V while the pin carries an id bit
    function [2:0] rr_next;
        input [2:0] ch;
        input role;
        begin
            rr_next = route_ch(ch + 3'h1, role);
        end
    endfunction

    // register writes
    always @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            chsel_q <= `ACV_RST_BYTE;
            cfg2_q <= `ACV_RST_BYTE;
            byp_q <= `ACV_RST_BYTE;
            low_low_threshold_select_q <= 1'b0;
            role_q <= 1'b0;
        end else if (reg_wr) begin
            case (reg_addr)
                `ACV_REG_CHSEL: chsel_q <= reg_wdata;
                `ACV_REG_CFG2: cfg2_q <= reg_wdata;
                `ACV_REG_BYP: byp_q <= reg_wdata;
                `ACV_REG_VID: begin
                    low_low_threshold_select_q <= reg_wdata[`ACV_VID_LOW_THRESHOLD_SELECT];
                    role_q <= reg_wdata[`ACV_VID_ROLE];
                end
                default: begin
                end
            endcase
        end
    end

    // identification pins sampled every cycle
    always @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            vid_q <= 6'h00;
        end else begin
            vid_q[4:0] <= voltage_id_pins;
            vid_q[5] <= role_q ? voltage_id_bit5_shared : 1'b0;
        end
    end

    // register reads, one cycle after the strobe
    always @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            reg_rdata <= `ACV_RST_BYTE;
            reg_rvalid <= 1'b0;
        end else begin
            reg_rvalid <= reg_rd;
            if (reg_rd) begin
                case (reg_addr)
                    `ACV_REG_CHSEL: reg_rdata <= chsel_q;
                    `ACV_REG_CFG2: reg_rdata <= cfg2_q;
                    `ACV_REG_BYP: reg_rdata <= byp_q;
                    `ACV_REG_VID: reg_rdata <= {role_q, low_low_threshold_select_q, vid_q};
                    default: reg_rdata <= `ACV_RST_BYTE;
                endcase
            end
        end
    end

    // conversion sequencer: settings latch when each conversion starts
    always @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            st_q <= ST_IDLE;
            tmr_q <= 20'h00000;
            cur_ch_q <= `ACV_CH_2V5;
            cur_single_q <= 1'b0;
            cur_avg_off_q <= 1'b0;
            adc_start <= 1'b0;
            adc_channel <= `ACV_CH_2V5;
            adc_atten_bypass <= 1'b0;
            sample_q <= `ACV_RST_CODE;
            sample_vld_q <= 1'b0;
        end else begin
            adc_start <= 1'b0;
            sample_vld_q <= 1'b0;
            case (st_q)
                ST_IDLE: begin
                    st_q <= ST_CONV;
                    tmr_q <= CONV_CYCLES - `ACV_SLOT_TRIM;
                    adc_start <= 1'b1;
                    cur_single_q <= cfg2_q[`ACV_CFG2_SINGLE];
                    cur_avg_off_q <= cfg2_q[`ACV_CFG2_AVG_OFF];
                    cur_ch_q <= start_ch;
                    adc_channel <= start_ch;
                    adc_atten_bypass <= byp_for(start_ch, cfg2_q, byp_q);
                end
                ST_CONV: begin
                    if (adc_done) begin
                        // saturate: raw carries one bit of headroom
                        sample_q <= adc_raw[10] ? `ACV_CODE_MAX : adc_raw[9:0];
                        sample_vld_q <= 1'b1;
                        st_q <= ST_WAIT;
                    end
                    if (tmr_q != 20'h00000) begin
                        tmr_q <= tmr_q - 20'h00001;
                    end
                end
                ST_WAIT: begin
                    // hold the 0.7 ms slot so repeats are evenly spaced
                    if (tmr_q == 20'h00000) begin
                        st_q <= ST_IDLE;
                    end else begin
                        tmr_q <= tmr_q - 20'h00001;
                    end
                end
                default: st_q <= ST_IDLE;
            endcase
            if (st_q == ST_CONV && tmr_q == 20'h00000 && !adc_done) begin
                st_q <= ST_IDLE;
            end
        end
    end

    // round-robin channel moves only after its result is done: sixteen samples, or one with averaging off
    wire chan_done = avg_vld;
    wire ch_change = (st_q == ST_IDLE) && (start_ch != cur_ch_q);

    always @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            vld_q <= 8'h00;
        end else if (chan_done) begin
            val_q[cur_ch_q] <= avg_res;
            vld_q[cur_ch_q] <= 1'b1;
        end
    end

    always @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            rr_ch_q <= `ACV_CH_2V5;
        end else if (chan_done && !cur_single_q) begin
            rr_ch_q <= rr_next(cur_ch_q, role_q);
        end
    end

    acv_avg u_avg (
        .ref_clk(ref_clk),
        .rst_n(rst_n),
        .clear(ch_change),
        .sample_valid(sample_vld_q),
        .sample(sample_q),
        .avg_off(cur_avg_off_q),
        .result_valid(avg_vld),
        .result(avg_res)
    );

    genvar gi;
    generate
        for (gi = 0; gi < 8; gi = gi + 1) begin : g_out
            always @(posedge ref_clk or negedge rst_n) begin
                if (!rst_n) begin
                    value_flat[gi*10 +: 10] <= `ACV_RST_CODE;
                end else begin
                    value_flat[gi*10 +: 10] <= vld_q[gi] ? val_q[gi] : `ACV_RST_CODE;
                end
            end
        end
    endgenerate

    always @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            value_valid <= 8'h00;
            low_threshold_select <= 1'b0;
            shared_pin_role_select <= 1'b0;
            single_mode <= 1'b0;
        end else begin
            value_valid <= vld_q;
            low_threshold_select <= low_low_threshold_select_q;
            shared_pin_role_select <= role_q;
            single_mode <= cur_single_q;
        end
    end
endmodule
`default_nettype wire

// ---- hw/acv_defs.vh ----
`ifndef ACV_DEFS_VH
`define ACV_DEFS_VH
// register map
`define ACV_REG_CHSEL 8'h55
`define ACV_REG_CFG2 8'h73
`define ACV_REG_BYP 8'h7D
`define ACV_REG_VID 8'h43
// field positions
`define ACV_CFG2_AVG_OFF 4
`define ACV_CFG2_BYP_ALL 5
`define ACV_CFG2_SINGLE 6
`define ACV_BYP_LO 4
`define ACV_CHSEL_HI 7
`define ACV_CHSEL_LO 5
`define ACV_VID_BIT5 5
`define ACV_VID_LOW_THRESHOLD_SELECT 6
`define ACV_VID_ROLE 7
// reset values
`define ACV_RST_BYTE 8'h00
`define ACV_RST_CODE 10'h000
// channel codes
`define ACV_CH_2V5 3'h0
`define ACV_CH_CORE 3'h1
`define ACV_CH_SUPPLY 3'h2
`define ACV_CH_5V0 3'h3
`define ACV_CH_12V 3'h4
`define ACV_CH_REM1 3'h5
`define ACV_CH_LOCAL 3'h6
`define ACV_CH_REM2 3'h7
// converter
`define ACV_CODE_MAX 10'h3FF
`define ACV_AVG_COUNT 5'h10
// 0.7 ms slot at 100 MHz
`define ACV_CONV_CYCLES 20'h11170
// the start cycle and the terminal count both sit inside the slot
`define ACV_SLOT_TRIM 20'h00002
`endif

// ---- hw/acv_avg.v ----
`timescale 1ns/10ps
`default_nettype none
`include "acv_defs.vh"
// sixteen-sample accumulator; bypassed when averaging is off
module acv_avg (
    input wire ref_clk,
    input wire rst_n,
    input wire clear,
    input wire sample_valid,
    input wire [9:0] sample,
    input wire avg_off,
    output reg result_valid,
    output reg [9:0] result
);
    reg [13:0] acc_q;
    reg [4:0] cnt_q;
    wire [13:0] sum = acc_q + {4'h0, sample};
    always @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            acc_q <= 14'h0000;
            cnt_q <= 5'h00;
            result_valid <= 1'b0;
            result <= `ACV_RST_CODE;
        end else begin
            result_valid <= 1'b0;
            if (clear) begin
                acc_q <= 14'h0000;
                cnt_q <= 5'h00;
            end else if (sample_valid) begin
                if (avg_off) begin
                    result <= sample;
                    result_valid <= 1'b1;
                end else if (cnt_q == `ACV_AVG_COUNT - 5'h01) begin
                    // divide by sixteen keeps the mean inside 0..1023
                    result <= sum[13:4];
                    result_valid <= 1'b1;
                    acc_q <= 14'h0000;
                    cnt_q <= 5'h00;
                end else begin
                    acc_q <= sum;
                    cnt_q <= cnt_q + 5'h01;
                end
            end
        end
    end
endmodule
`default_nettype wire

// ---- verification/acv_checker_assertions.sv ----
`timescale 1ns/10ps
`default_nettype none
module acv_checker (
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic reg_rd,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_rdata,
    input wire logic reg_rvalid,
    input wire logic adc_start,
    input wire logic [2:0] adc_channel,
    input wire logic low_threshold_select,
    input wire logic shared_pin_role_select
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!rst_n);
    AST_RVALID_AFTER_READ: assert property (reg_rd |=> reg_rvalid)
        else $error("read strobe got no data valid");
    AST_RVALID_CAUSE: assert property (reg_rvalid |-> $past(reg_rd))
        else $error("data valid without read");
    AST_VOLTAGE_ID_BIT5_SHARED_ZERO: assert property (reg_rvalid && $past(reg_addr) == 8'h43
        && !$past(shared_pin_role_select) |-> !reg_rdata[5])
        else $error("shared id bit not zero in measure role");
    AST_ROLE_READ: assert property (reg_rvalid && $past(reg_addr) == 8'h43
        |-> reg_rdata[7] == shared_pin_role_select)
        else $error("role bit readback wrong");
    AST_LOW_THRESHOLD_SELECT_READ: assert property (reg_rvalid && $past(reg_addr) == 8'h43
        |-> reg_rdata[6] == low_threshold_select)
        else $error("threshold bit readback wrong");
    AST_START_GAP: assert property (adc_start |=> !adc_start [*8])
        else $error("conversion starts too close");
    AST_CH_STABLE: assert property (adc_start |=> $stable(adc_channel) [*8])
        else $error("channel moved within slot");
    AST_ROLE_SKIP: assert property (adc_start && $past(shared_pin_role_select)
        && shared_pin_role_select |-> adc_channel != 3'h4)
        else $error("shared pin measured while id input");
endmodule
`default_nettype wire

// ---- verification/acv_conv_model.sv ----
`timescale 1ns/10ps
`default_nettype none
// converter stand-in: answers each start after lat cycles with the given raw code
module acv_conv_model (
    input wire logic ref_clk,
    input wire logic adc_start,
    input wire logic [10:0] code,
    input wire logic [7:0] lat,
    output logic adc_done,
    output logic [10:0] adc_raw
);
    initial begin
        adc_done = 1'b0;
        adc_raw = 11'h7FF;
        forever begin
            @(posedge ref_clk);
            if (adc_start) begin
                repeat (lat) @(posedge ref_clk);
                #1 adc_done = 1'b1;
                adc_raw = code;
                @(posedge ref_clk);
                // result no longer held: show the inverse, not a stale copy
                #1 adc_done = 1'b0;
                adc_raw = ~code;
            end
        end
    end
endmodule
`default_nettype wire

// ---- verification/tb_top.sv ----
`timescale 1ns/10ps
`default_nettype none
module tb_top;
    logic ref_clk = 1'b0, rst_n = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
    logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata, value_valid;
    logic reg_rvalid, adc_done, adc_start, adc_atten_bypass, single_mode;
    logic [4:0] voltage_id_pins = 5'h00;
    logic voltage_id_bit5_shared = 1'b0, low_threshold_select, shared_pin_role_select;
    logic [10:0] adc_raw;
    logic [2:0] adc_channel;
    logic [79:0] value_flat;
    int bad_count = 0, check_count = 0;
    always #5 ref_clk = ~ref_clk;
    acv_ctrl acv_ctrl_inst (.ref_clk(ref_clk), .rst_n(rst_n), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
        .reg_rvalid(reg_rvalid), .voltage_id_pins(voltage_id_pins),
        .voltage_id_bit5_shared(voltage_id_bit5_shared), .adc_done(adc_done),
        .adc_raw(adc_raw), .adc_start(adc_start), .adc_channel(adc_channel),
        .adc_atten_bypass(adc_atten_bypass), .low_threshold_select(low_threshold_select),
        .shared_pin_role_select(shared_pin_role_select), .single_mode(single_mode),
        .value_valid(value_valid), .value_flat(value_flat));
    acv_conv_model acv_conv_model_inst (.ref_clk(ref_clk), .adc_start(adc_start),
        .code(11'h4AB), .lat(8'h05), .adc_done(adc_done), .adc_raw(adc_raw));
    task automatic give_verdict;
        $display("checks %0d mismatches %0d", check_count, bad_count);
        if (bad_count == 0 && check_count > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    task automatic chk(input string what, input logic [79:0] exp, input logic [79:0] got);
        check_count++;
        if (got !== exp) begin
            bad_count++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        #1 reg_wr = 1'b1;
        reg_addr = a;
        reg_wdata = d;
        @(posedge ref_clk);
        #1 reg_wr = 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        @(posedge ref_clk);
        #1 reg_rd = 1'b1;
        reg_addr = a;
        @(posedge ref_clk);
        #1 reg_rd = 1'b0;
        chk("rvalid", 1'b1, reg_rvalid);
        chk($sformatf("reg %h", a), exp, reg_rdata);
    endtask
    task automatic test_regs;
        rd(8'h55, 8'h00);
        rd(8'h73, 8'h00);
        rd(8'h7D, 8'h00);
        rd(8'h43, 8'h00);
        wr(8'h10, 8'hFF);
        rd(8'h10, 8'h00);
        wr(8'h7D, 8'hF0);
        rd(8'h7D, 8'hF0);
        wr(8'h55, 8'hA5);
        rd(8'h55, 8'hA5);
    endtask
    task automatic test_vid;
        voltage_id_pins = 5'h15;
        voltage_id_bit5_shared = 1'b1;
        repeat (2) @(posedge ref_clk);
        rd(8'h43, 8'h15);
        wr(8'h43, 8'hC0);
        rd(8'h43, 8'hF5);
        chk("low_threshold_select", 1'b1, low_threshold_select);
        chk("role", 1'b1, shared_pin_role_select);
        wr(8'h43, 8'h00);
    endtask
    task automatic test_single;
        int n;
        // channel code 011 in the top bits; the tach limit byte changes with it
        wr(8'h55, 8'h60);
        wr(8'h7D, 8'h40);
        wr(8'h43, 8'h80);
        wr(8'h73, 8'h50);
        rd(8'h73, 8'h50);
        n = 0;
        while (!(adc_start && adc_channel === 3'h3) && n < 71000) begin
            @(posedge ref_clk);
            #1 n++;
        end
        chk("start seen", 1'b1, n < 71000);
        chk("bypass 5V", 1'b1, adc_atten_bypass);
        n = 0;
        while (value_valid[3] !== 1'b1 && n < 20) begin
            @(posedge ref_clk);
            #1 n++;
        end
        chk("single", 1'b1, single_mode);
        chk("value 5V", 10'h3FF, value_flat[39:30]);
        chk("valid", 8'h08, value_valid);
        chk("others", 70'h0, {value_flat[79:40], value_flat[29:0]});
    endtask
    initial begin
        repeat (3) @(posedge ref_clk);
        #1 rst_n = 1'b1;
        test_regs();
        test_vid();
        test_single();
        give_verdict();
    end
    initial begin
        #1000000;
        bad_count++;
        give_verdict();
    end
endmodule
bind acv_ctrl acv_checker acv_checker_inst (.ref_clk(ref_clk), .rst_n(rst_n),
    .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
    .adc_start(adc_start), .adc_channel(adc_channel),
    .low_threshold_select(low_threshold_select),
    .shared_pin_role_select(shared_pin_role_select));
`default_nettype wire
